// ===== design/cfl_pkg.sv
// constants, state codes and register layout shared by the flash configuration loader
package cfl_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;                 // loader clock, 250 MHz

  // least time in ns to whole cycles, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SYNC_LAG        = 2;               // flip-flops in each pin synchroniser
  localparam int FRST_LOW_NS     = 500;             // flash reset pulse width
  localparam int FRST_LOW_CYC    = cyc_up(FRST_LOW_NS);
  localparam int NCFG_LOW_NS     = 2000;            // configuration-request low pulse
  localparam int NCFG_LOW_CYC    = cyc_up(NCFG_LOW_NS);
  localparam int RD_ACC_NS       = 100;             // asynchronous flash read access time
  localparam int RD_WAIT_CYC     = cyc_up(RD_ACC_NS) + SYNC_LAG;
  localparam int ADV_LOW_CYC     = 4;               // one full burst clock period, worst divider
  localparam int WDOG_TIMEOUT_MS = 100;             // watchdog period
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // widths
  localparam int FLASH_AW   = 24;
  localparam int FLASH_DW   = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W      = 16;
  localparam int WDOG_W     = 32;
  localparam int SYNC_N     = 7;
  localparam int PEND_N     = 3;                    // burst edge to capture pipeline

  // ==========================================================================
  // positions in the pin synchroniser vector
  localparam int SI_KICK = 0;                       // watchdog retrigger
  localparam int SI_DONE = 1;                       // configuration done
  localparam int SI_STAT = 2;                       // fpga status, low is error
  localparam int SI_RECF = 3;                       // reconfiguration request, low active
  localparam int SI_GRNT = 4;                       // flash access granted
  localparam int SI_RDY  = 5;                       // configuration sink ready
  localparam int SI_RQIN = 6;                       // level seen on configuration-request line

  localparam logic [FLASH_AW-1:0] START_ADDR = 24'h000000;

  // ==========================================================================
  // loader states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_FRST  = 8'h02,
    ST_NCFG  = 8'h04,
    ST_WSTAT = 8'h08,
    ST_BADV  = 8'h10,
    ST_BREAD = 8'h20,
    ST_AREAD = 8'h40,
    ST_END   = 8'h80
  } cfl_state_t;

  // ==========================================================================
  // complete loader state
  typedef struct packed {
    cfl_state_t              st;
    logic [SYNC_N-1:0]       s1;
    logic [SYNC_N-1:0]       s2;
    logic [FLASH_DW-1:0]     d1;
    logic [FLASH_DW-1:0]     d2;
    logic [CNT_W-1:0]        cnt;
    logic [WDOG_W-1:0]       wdog;
    logic                    kick_acc;
    logic                    kick_hold;
    logic                    div;
    logic                    bclk;
    logic [PEND_N-1:0]       pend;
    logic                    oe_b;
    logic                    adv_b;
    logic                    frst_b;
    logic                    ncfg_oe;
    logic                    acc_req;
    logic                    wdog_err;
    logic                    cfg_err;
    logic                    done;
    logic [FLASH_AW-1:0]     addr;
    logic                    push;
    logic [FLASH_DW-1:0]     push_data;
  } cfl_regs_t;

  localparam cfl_regs_t REGS_RST = '{
    st: ST_IDLE, s1: 7'h7f, s2: 7'h7f, d1: 16'h0000, d2: 16'h0000, cnt: 16'h0000,
    wdog: 32'h00000000, kick_acc: 1'b0, kick_hold: 1'b0, div: 1'b0, bclk: 1'b0,
    pend: 3'h0, oe_b: 1'b1, adv_b: 1'b1, frst_b: 1'b0, ncfg_oe: 1'b0, acc_req: 1'b0,
    wdog_err: 1'b0, cfg_err: 1'b0, done: 1'b0, addr: START_ADDR, push: 1'b0,
    push_data: 16'h0000};

endpackage

// ===== design/cfl_fifo.sv
// small synchronous fifo between flash reads and the configuration data output
`timescale 1ns/1ps

module cfl_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic                 clk,       // loader clock
  input  wire logic                 rst_b,     // async reset, low active
  input  wire logic                 ce,        // clock enable, freezes all state
  input  wire logic                 in_valid,  // word offered
  output logic                      in_ready,  // room for a word
  input  wire logic [W-1:0]         in_data,   // word in
  output logic                      out_valid, // word available
  input  wire logic                 out_ready, // drain side takes word
  output logic [W-1:0]              out_data,  // head word, from storage flops
  output logic [$clog2(D+1)-1:0]    level      // words held
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int LW = $clog2(D+1);

  // ==========================================================================
  // storage and pointers
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [LW-1:0] cnt;
  logic          do_wr;
  logic          do_rd;

  // pointer wrap for a depth that need not be a power of two
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest full and empty flags
  assign in_ready  = (cnt != LW'(D));
  assign out_valid = (cnt != '0);
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];
  assign level     = cnt;

  // pointer and count update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_rd) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      cnt <= cnt + LW'(do_wr) - LW'(do_rd);
    end
  end

  // data array has no reset, contents only read when counted valid
  always_ff @(posedge clk) begin
    if (ce && do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // cfl_fifo

// ===== design/cfl_loader.sv
// parallel flash configuration loader: flash strobes, burst clock, fpga config request, watchdog
// How it works
// - write strobe low only for flash writes
// - output strobe low while reading flash
// - single flash: burst clock is half rate
// - dual flash: burst clock is quarter rate
// - burst pins only used in burst mode
// - address-valid low pulse latches burst start
// - flash reset low resets, high runs
// - low pulse on open-drain config request
// - watchdog error output high on error
// - fpga status low: error, stop reading
// - config done high means success
// - access request high; wait for grant
// - registered reconfiguration request restarts configuration, except after a watchdog error
`timescale 1ns/1ps

module cfl_loader #(
  parameter int WDOG_CYC = cfl_pkg::WDOG_TIMEOUT_CYC
) (
  input  wire logic                         clk,            // loader clock, 250 MHz
  input  wire logic                         rst_b,          // async reset, low active
  input  wire logic                         ce,             // clock enable
  input  wire logic                         burst_en,       // burst mode select
  input  wire logic                         dual_flash,     // two flash devices
  output logic [cfl_pkg::FLASH_AW-1:0]      flash_addr,     // flash word address
  input  wire logic [cfl_pkg::FLASH_DW-1:0] flash_data_in,  // flash data pins
  output logic                              flash_we_b,     // flash write strobe
  output logic                              flash_oe_b,     // flash output strobe
  output logic                              flash_bclk,     // burst clock
  output logic                              flash_adv_b,    // burst address valid
  output logic                              flash_rst_b,    // flash reset
  input  wire logic                         cfg_req_in,     // config-request line level
  output logic                              cfg_req_out,    // config-request drive value
  output logic                              cfg_req_oe,     // config-request drive enable
  input  wire logic                         fpga_done,      // fpga configuration done
  input  wire logic                         fpga_status_b,  // fpga status, low is error
  output logic [cfl_pkg::FLASH_DW-1:0]      cfg_data,       // configuration word
  output logic                              cfg_valid,      // configuration word valid
  input  wire logic                         cfg_ready,      // configuration sink ready
  input  wire logic                         reconf_b,       // reconfiguration request
  input  wire logic                         acc_granted,    // flash access granted
  output logic                              acc_req,        // flash access request
  input  wire logic                         wdog_kick,      // watchdog retrigger level
  output logic                              wdog_err,       // watchdog error
  output logic                              cfg_err,        // fpga reported an error
  output logic                              cfg_ok          // configuration succeeded
);

  localparam int LW = $clog2(cfl_pkg::FIFO_DEPTH + 1);

  cfl_pkg::cfl_regs_t r;
  cfl_pkg::cfl_regs_t n;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [LW-1:0]      fifo_level;
  logic               loading;

  // ==========================================================================
  // helpers
  localparam int CNT_W_L = cfl_pkg::CNT_W;
  function automatic logic [CNT_W_L-1:0] cnt_inc(input logic [CNT_W_L-1:0] c);
    return c + 1'b1;
  endfunction

  // words that will land in the fifo: held, queued for push, and edges in flight
  function automatic logic [LW+1:0] committed(input logic [LW-1:0] lvl, input logic psh,
                                              input logic [cfl_pkg::PEND_N-1:0] pnd);
    return (LW+2)'(lvl) + (LW+2)'(psh) + (LW+2)'(pnd[0]) + (LW+2)'(pnd[1]) + (LW+2)'(pnd[2]);
  endfunction

  assign loading = (r.st == cfl_pkg::ST_BADV) || (r.st == cfl_pkg::ST_BREAD) ||
                   (r.st == cfl_pkg::ST_AREAD);

  // ==========================================================================
  // next state
  always_comb begin
    logic kick;
    logic granted;
    logic room;
    kick      = 1'b0;
    granted   = r.s2[cfl_pkg::SI_GRNT];
    room      = committed(fifo_level, r.push, r.pend) < (LW+2)'(cfl_pkg::FIFO_DEPTH);
    n         = r;
    // pins pass two flops; only s2 is looked at
    n.s1      = {cfg_req_in, cfg_ready, acc_granted, reconf_b, fpga_status_b, fpga_done, wdog_kick};
    n.s2      = r.s1;
    n.d1      = flash_data_in;
    n.d2      = r.d1;
    n.push    = 1'b0;
    n.pend    = {r.pend[cfl_pkg::PEND_N-2:0], 1'b0};

    // retrigger accepted only after a new level stood two cycles
    if (r.s2[cfl_pkg::SI_KICK] != r.kick_acc) begin
      if (r.kick_hold) begin
        n.kick_acc  = r.s2[cfl_pkg::SI_KICK];
        n.kick_hold = 1'b0;
        kick        = 1'b1;
      end else begin
        n.kick_hold = 1'b1;
      end
    end else begin
      n.kick_hold = 1'b0;
    end

    // captured burst word from an edge three cycles back, covers the pin sync lag
    if (r.pend[cfl_pkg::PEND_N-1]) begin
      n.push      = 1'b1;
      n.push_data = r.d2;
    end

    case (r.st)
      cfl_pkg::ST_IDLE: begin
        n.acc_req = 1'b1;
        if (granted) begin
          n.st     = cfl_pkg::ST_FRST;
          n.frst_b = 1'b0;
          n.cnt    = '0;
        end
      end
      cfl_pkg::ST_FRST: begin
        n.cnt = cnt_inc(r.cnt);
        if (r.cnt == CNT_W_L'(cfl_pkg::FRST_LOW_CYC - 1)) begin
          n.frst_b  = 1'b1;
          n.ncfg_oe = 1'b1;
          n.st      = cfl_pkg::ST_NCFG;
          n.cnt     = '0;
        end
      end
      cfl_pkg::ST_NCFG: begin
        // pulse stretched while reconfiguration stays requested
        if (r.cnt != CNT_W_L'(cfl_pkg::NCFG_LOW_CYC - 1)) begin
          n.cnt = cnt_inc(r.cnt);
        end else if (r.s2[cfl_pkg::SI_RECF]) begin
          n.ncfg_oe = 1'b0;
          n.st      = cfl_pkg::ST_WSTAT;
        end
      end
      cfl_pkg::ST_WSTAT: begin
        // line must float back high and fpga must report ready first
        if (r.s2[cfl_pkg::SI_RQIN] && r.s2[cfl_pkg::SI_STAT] && granted) begin
          n.addr = cfl_pkg::START_ADDR;
          n.cnt  = '0;
          if (burst_en) begin
            n.st    = cfl_pkg::ST_BADV;
            n.adv_b = 1'b0;
          end else begin
            n.st = cfl_pkg::ST_AREAD;
          end
        end
      end
      cfl_pkg::ST_BADV: begin
        n.cnt = cnt_inc(r.cnt);
        if (r.cnt == CNT_W_L'(cfl_pkg::ADV_LOW_CYC - 1)) begin
          n.adv_b = 1'b1;
          n.oe_b  = 1'b0;
          n.st    = cfl_pkg::ST_BREAD;
          n.div   = 1'b0;
        end
      end
      cfl_pkg::ST_BREAD: begin
        n.oe_b = !granted;
        // falling edge always completes; a rising edge waits for room and grant
        if (r.bclk) begin
          if (!dual_flash || r.div) begin
            n.bclk = 1'b0;
            n.div  = 1'b0;
          end else begin
            n.div = 1'b1;
          end
        end else if (granted && room) begin
          if (!dual_flash || r.div) begin
            n.bclk    = 1'b1;
            n.div     = 1'b0;
            n.pend[0] = 1'b1;
            n.addr    = r.addr + 1'b1;
          end else begin
            n.div = 1'b1;
          end
        end
      end
      cfl_pkg::ST_AREAD: begin
        n.oe_b = !granted;
        // losing the grant abandons the read in flight; it restarts in full, never pushes a floating bus
        if (!granted || (r.cnt == '0 && !(room && fifo_in_ready))) begin
          n.cnt = '0;
        end else if (r.cnt == CNT_W_L'(cfl_pkg::RD_WAIT_CYC - 1)) begin
          n.push      = 1'b1;
          n.push_data = r.d2;
          n.addr      = r.addr + 1'b1;
          n.cnt       = '0;
        end else begin
          n.cnt = cnt_inc(r.cnt);
        end
      end
      cfl_pkg::ST_END: begin
        n.acc_req = 1'b0;
      end
      default: begin
        n.st = cfl_pkg::ST_END;
      end
    endcase

    // outcome of the fpga ends reading and frees the flash
    if (loading && !r.s2[cfl_pkg::SI_STAT]) begin
      n.cfg_err = 1'b1;
      n.st      = cfl_pkg::ST_END;
    end else if (loading && r.s2[cfl_pkg::SI_DONE]) begin
      n.done = 1'b1;
      n.st   = cfl_pkg::ST_END;
    end

    // watchdog runs from the flash reset pulse until the load ends
    if (kick || r.st == cfl_pkg::ST_IDLE || r.st == cfl_pkg::ST_END) begin
      n.wdog = '0;
    end else if (r.wdog == cfl_pkg::WDOG_W'(WDOG_CYC - 1)) begin
      n.wdog_err = 1'b1;
      n.st       = cfl_pkg::ST_END;
    end else begin
      n.wdog = r.wdog + 1'b1;
    end

    // reconfiguration restarts the request pulse; a watchdog error blocks it
    if (!r.s2[cfl_pkg::SI_RECF] && !r.wdog_err && !n.wdog_err &&
        r.st != cfl_pkg::ST_IDLE && r.st != cfl_pkg::ST_FRST && r.st != cfl_pkg::ST_NCFG) begin
      n.st      = cfl_pkg::ST_NCFG;
      n.ncfg_oe = 1'b1;
      n.cnt     = '0;
      n.done    = 1'b0;
      n.cfg_err = 1'b0;
      n.acc_req = 1'b1;
    end

    // leaving the read states parks every flash strobe
    if (n.st != cfl_pkg::ST_BREAD && n.st != cfl_pkg::ST_AREAD) begin
      n.oe_b = 1'b1;
      n.bclk = 1'b0;
    end
    if (n.st != cfl_pkg::ST_BADV) begin
      n.adv_b = 1'b1;
    end
    if (n.st == cfl_pkg::ST_END) begin
      n.acc_req = 1'b0;
    end
  end

  // ==========================================================================
  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= cfl_pkg::REGS_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // ==========================================================================
  // word buffer; the flash side stalls through the room term above
  cfl_fifo #(
    .W (cfl_pkg::FLASH_DW),
    .D (cfl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (r.push),
    .in_ready  (fifo_in_ready),
    .in_data   (r.push_data),
    .out_valid (fifo_out_valid),
    .out_ready (cfg_valid && r.s2[cfl_pkg::SI_RDY]),
    .out_data  (cfg_data),
    .level     (fifo_level)
  );

  // ==========================================================================
  // outputs; the loader never writes flash so the write strobe stays high
  assign flash_we_b  = 1'b1;
  assign flash_oe_b  = r.oe_b;
  assign flash_bclk  = r.bclk;
  assign flash_adv_b = r.adv_b;
  assign flash_rst_b = r.frst_b;
  assign flash_addr  = r.addr;
  assign cfg_req_out = 1'b0;
  assign cfg_req_oe  = r.ncfg_oe;
  assign cfg_valid   = fifo_out_valid && loading;
  assign acc_req     = r.acc_req;
  assign wdog_err    = r.wdog_err;
  assign cfg_err     = r.cfg_err;
  assign cfg_ok      = r.done;

endmodule // cfl_loader

// ===== verification/cfl_loader_sva.sv
// concurrent checks on the flash configuration loader ports
`timescale 1ns/1ps
// ==========================================
// port checker
module cfl_loader_sva #(
  parameter int WDOG_CYC = 2000
) (
  input wire logic clk,         // loader clock
  input wire logic rst_b,       // async reset, low active
  input wire logic burst_en,    // burst mode select
  input wire logic dual_flash,  // two flash devices
  input wire logic acc_granted, // flash access granted
  input wire logic flash_we_b,  // write strobe
  input wire logic flash_oe_b,  // output strobe
  input wire logic flash_bclk,  // burst clock
  input wire logic flash_adv_b, // address valid
  input wire logic flash_rst_b, // flash reset
  input wire logic cfg_req_out, // open-drain drive value
  input wire logic cfg_req_oe,  // open-drain drive enable
  input wire logic wdog_err,    // watchdog error
  input wire logic cfg_err      // fpga error seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] lo_n, oe_n, run_n;
  // pulse widths; a long pulse is only known once it ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_n <= '0;
      oe_n <= '0;
      run_n <= '0;
    end else begin
      lo_n <= flash_rst_b ? 32'h0 : lo_n + 32'h1;
      oe_n <= cfg_req_oe ? oe_n + 32'h1 : 32'h0;
      run_n <= run_n + 32'h1;
    end
  end
  a_we_idle: assert property (flash_we_b)
    else $error("write strobe driven low");
  a_strobe_excl: assert property (flash_we_b || flash_oe_b)
    else $error("both strobes low");
  a_oe_grant: assert property (!acc_granted [*4] |-> flash_oe_b)
    else $error("flash read without grant");
  a_bclk_read: assert property ($rose(flash_bclk) |-> !flash_oe_b)
    else $error("burst edge outside read");
  a_bclk_half: assert property ($rose(flash_bclk) && !dual_flash |=> !flash_bclk)
    else $error("burst clock not half rate");
  // a load that ends parks the clock early, seen with the output strobe released
  a_bclk_qtr: assert property ($rose(flash_bclk) && dual_flash |=>
    ((!flash_bclk && flash_oe_b) or (flash_bclk ##1 !flash_bclk)))
    else $error("burst clock not quarter rate");
  a_burst_only: assert property (!burst_en |-> !flash_bclk && flash_adv_b)
    else $error("burst pins active outside burst");
  a_adv_pulse: assert property ($fell(flash_adv_b) |-> !flash_adv_b [*4] ##1 flash_adv_b)
    else $error("address valid pulse width");
  a_frst_width: assert property ($rose(flash_rst_b) |-> lo_n >= cfl_pkg::FRST_LOW_CYC)
    else $error("flash reset pulse short");
  a_ncfg_pulse: assert property ($fell(cfg_req_oe) |-> oe_n >= cfl_pkg::NCFG_LOW_CYC && !cfg_req_out)
    else $error("config request pulse short");
  a_wdog_sticky: assert property (wdog_err |=> wdog_err)
    else $error("watchdog error dropped");
  a_wdog_early: assert property ($rose(wdog_err) |-> run_n >= WDOG_CYC)
    else $error("watchdog error too early");
  a_err_stop: assert property (cfg_err |=> flash_oe_b)
    else $error("flash read after fpga error");
endmodule // cfl_loader_sva

bind cfl_loader cfl_loader_sva #(.WDOG_CYC(WDOG_CYC)) u_sva (.clk(clk), .rst_b(rst_b), .burst_en(burst_en),
  .dual_flash(dual_flash), .acc_granted(acc_granted), .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b),
  .flash_bclk(flash_bclk), .flash_adv_b(flash_adv_b), .flash_rst_b(flash_rst_b), .cfg_req_out(cfg_req_out),
  .cfg_req_oe(cfg_req_oe), .wdog_err(wdog_err), .cfg_err(cfg_err));

// ===== verification/cfl_flash_model.sv
// parallel flash and fpga config-request line as seen by the loader
`timescale 1ns/1ps
// ==========================================
// far-side model
module cfl_flash_model (
  input wire logic        clk,    // loader clock
  input wire logic        burst,  // burst mode strapped
  input wire logic [23:0] addr,   // word address
  input wire logic        oe_b,   // output strobe
  input wire logic        bclk,   // burst clock
  input wire logic        adv_b,  // address valid
  input wire logic        frst_b, // flash reset
  input wire logic        req_oe, // loader pulls request line low
  output logic [15:0]     data,   // flash data pins
  output logic            req_in  // request line level
);
  logic [23:0] bcnt  = '0;
  logic [15:0] last  = '0;
  logic        first = 1'b0;
  logic        drv;
  // start address taken as address valid ends; first edge shows it, later edges advance
  always @(posedge bclk or posedge adv_b) begin
    if (!bclk) begin
      bcnt  <= addr;
      first <= 1'b1;
    end else if (first) begin
      first <= 1'b0;
    end else begin
      bcnt <= bcnt + 24'h000001;
    end
  end
  // released bus shows the inverse of the last word, never a stale match
  assign drv = !oe_b && frst_b;
  assign data = drv ? ((burst ? bcnt[15:0] : addr[15:0]) ^ 16'h5a3c) : ~last;
  always @(posedge clk) begin
    if (drv) last <= data;
  end
  // pull-up on the request line
  assign req_in = req_oe ? 1'b0 : 1'b1;
endmodule // cfl_flash_model

// ===== verification/tb_cfi_flash_config_loader.sv
// self-checking bench for the flash configuration loader
`timescale 1ns/1ps
// ==========================================
// bench top
module tb_cfi_flash_config_loader;
  typedef struct {logic b; logic d; int n; logic v;} cfl_row_t;
  logic clk = 0, rst_b = 0, burst_en = 0, dual_flash = 0, fpga_done = 0, fpga_status_b = 1;
  logic cfg_ready = 0, reconf_b = 1, acc_granted = 0, wdog_kick = 0, rd1 = 0, rd2 = 0;
  logic [23:0] flash_addr, a_hold;
  logic [15:0] flash_data_in, cfg_data, q[$];
  logic flash_we_b, flash_oe_b, flash_bclk, flash_adv_b, flash_rst_b, cfg_req_in, cfg_req_out;
  logic cfg_req_oe, cfg_valid, acc_req, wdog_err, cfg_err, cfg_ok;
  int err_total = 0, checks = 0, cyc = 0;
  // burst, dual, words to take, compare values
  cfl_row_t rows[3] = '{'{0, 0, 6, 1}, '{1, 0, 6, 1}, '{1, 1, 6, 1}};

  always #2 clk = ~clk;

  cfl_loader #(.WDOG_CYC(2000)) DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .burst_en(burst_en),
    .dual_flash(dual_flash), .flash_addr(flash_addr), .flash_data_in(flash_data_in), .flash_we_b(flash_we_b),
    .flash_oe_b(flash_oe_b), .flash_bclk(flash_bclk), .flash_adv_b(flash_adv_b), .flash_rst_b(flash_rst_b),
    .cfg_req_in(cfg_req_in), .cfg_req_out(cfg_req_out), .cfg_req_oe(cfg_req_oe), .fpga_done(fpga_done),
    .fpga_status_b(fpga_status_b), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
    .reconf_b(reconf_b), .acc_granted(acc_granted), .acc_req(acc_req), .wdog_kick(wdog_kick),
    .wdog_err(wdog_err), .cfg_err(cfg_err), .cfg_ok(cfg_ok));

  cfl_flash_model u_flash (.clk(clk), .burst(burst_en), .addr(flash_addr), .oe_b(flash_oe_b),
    .bclk(flash_bclk), .adv_b(flash_adv_b), .frst_b(flash_rst_b), .req_oe(cfg_req_oe),
    .data(flash_data_in), .req_in(cfg_req_in));

  // word taken where valid meets the ready level of two edges back
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cfg_valid === 1'b1 && rd2 === 1'b1) q.push_back(cfg_data);
    rd2 <= rd1;
    rd1 <= cfg_ready;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk_bit(string nm, logic e, logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(string nm, logic [23:0] e, logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait, the caller checks the level afterwards
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
  endtask

  task automatic do_reset(logic b, logic d);
    @(negedge clk);
    rst_b = 0;
    burst_en = b;
    dual_flash = d;
    acc_granted = 1;
    cfg_ready = 0;
    fpga_done = 0;
    repeat (16) @(negedge clk);
    chk_bit("flash_rst_b", 0, flash_rst_b);
    chk_bit("wdog_err", 0, wdog_err);
    chk_bit("cfg_req_oe", 0, cfg_req_oe);
    rst_b = 1;
    q.delete();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    int i, k;
    for (i = 0; i < 3; i++) begin
      do_reset(rows[i].b, rows[i].d);
      wait_for(cfg_valid, 1, 1500);
      // sink stalls until the fifo refuses, then drains
      repeat (300) @(negedge clk);
      if (!rows[i].b) chk_bit("stall oe", 0, flash_oe_b);
      if (!rows[i].b) chk_word("stall addr", 24'h000004, flash_addr);
      cfg_ready = 1;
      for (k = 0; k < 3000 && q.size() < rows[i].n; k++) @(negedge clk);
      chk_bit("words", 1, q.size() >= rows[i].n);
      for (k = 0; k < rows[i].n && rows[i].v; k++) chk_word("data", {8'h00, k[15:0] ^ 16'h5a3c}, {8'h00, q[k]});
      fpga_done = 1;
      wait_for(cfg_ok, 1, 10);
      chk_bit("cfg_ok", 1, cfg_ok);
      repeat (2) @(negedge clk);
      chk_bit("acc_req", 0, acc_req);
      $display("row %0d done", i);
    end
    // fpga error mid-load, restart, grant taken away
    do_reset(0, 0);
    cfg_ready = 1;
    wait_for(cfg_valid, 1, 1500);
    fpga_status_b = 0;
    wait_for(cfg_err, 1, 10);
    chk_bit("cfg_err", 1, cfg_err);
    wdog_kick = ~wdog_kick;
    a_hold = flash_addr;
    repeat (100) @(negedge clk);
    chk_word("addr frozen", a_hold, flash_addr);
    fpga_status_b = 1;
    reconf_b = 0;
    wait_for(cfg_req_oe, 1, 10);
    chk_bit("restart", 1, cfg_req_oe);
    reconf_b = 1;
    wait_for(flash_oe_b, 0, 800);
    chk_bit("cfg_err clear", 0, cfg_err);
    acc_granted = 0;
    repeat (5) @(negedge clk);
    chk_bit("oe no grant", 1, flash_oe_b);
    acc_granted = 1;
    $display("error and restart test done");
    // watchdog kept alive by level changes, then left to run out
    cfg_ready = 0;
    for (k = 0; k < 4; k++) begin
      wdog_kick = ~wdog_kick;
      repeat (800) @(negedge clk);
    end
    chk_bit("wdog alive", 0, wdog_err);
    wait_for(wdog_err, 1, 2100);
    chk_bit("wdog expiry", 1, wdog_err);
    reconf_b = 0;
    repeat (20) @(negedge clk);
    chk_bit("reconf ignored", 0, cfg_req_oe);
    chk_bit("wdog sticky", 1, wdog_err);
    reconf_b = 1;
    $display("watchdog test done");
    give_verdict();
  end
endmodule // tb_cfi_flash_config_loader
